//--- hw/lcdd_defs.vh
// register map, field positions, clear fill values and timing for the lcd decoder
`ifndef LCDD_DEFS_VH
`define LCDD_DEFS_VH

// axi4-lite register byte offsets
`define LCDD_AW 8
`define LCDD_OFS_CMD 8'h00
`define LCDD_OFS_RESULT 8'h04
`define LCDD_OFS_STATUS 8'h08
`define LCDD_OFS_MODE 8'h0c
`define LCDD_OFS_EXTCFG 8'h10
`define LCDD_RESP_OKAY 2'b00
`define LCDD_RESP_SLVERR 2'b10

// command word layout
`define LCDD_CMD_RS 9
`define LCDD_CMD_RW 8

// status register fields
`define LCDD_ST_BUSY 0
`define LCDD_ST_EXT 1
`define LCDD_ST_GLYPH 2
`define LCDD_ST_AC_LSB 8
`define LCDD_ST_SHIFT_LSB 16

// mode register fields
`define LCDD_MD_DISP 0
`define LCDD_MD_CUR 1
`define LCDD_MD_BLINK 2
`define LCDD_MD_WIDE 3
`define LCDD_MD_TWOLINE 4
`define LCDD_MD_INC 5
`define LCDD_MD_AUTO 6

// extended config fields
`define LCDD_EX_BIAS_LSB 0
`define LCDD_EX_INTRES 2
`define LCDD_EX_SCAN_LSB 4
`define LCDD_EX_LEN_LSB 8

// clear fill pattern and last text address of the fill
`define LCDD_SPACE_CODE 8'h20
`define LCDD_LAST_TEXT 7'h7f

// timing: times in ns, clock period in ns
`define LCDD_CLK_NS 5
`define LCDD_CLEAR_NS 1520000
`define LCDD_EXEC_NS 37000
`define LCDD_CLEAR_CYC (`LCDD_CLEAR_NS / `LCDD_CLK_NS)
`define LCDD_EXEC_CYC (`LCDD_EXEC_NS / `LCDD_CLK_NS)

`endif

//--- hw/lcdd_ram.v
// combined text and glyph ram with registered read data
`timescale 1ns/1ps
module lcdd_ram (
  // clock
  input wire core_clk,
  // write port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  // read port
  input wire rd_en,
  input wire [7:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:255];

  // contents are not reset; software clears the text area by command
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

//--- hw/lcdd_core.v
// character lcd instruction decoder with axi4-lite command port
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "lcdd_defs.vh"
// Functional notes
// - basic set plus common commands when extended clear
// - extended set decodes overlapping codes as extended
// - set switches only through function set
// - clear fills spaces, zeroes counter, long busy
// - home zeroes counter and display shift
// - display control latches enable, cursor, blink
// - shift moves cursor or display only
// - function set latches bus width, line count
// - status read returns busy and counter
// - data write stores byte into selected ram
// - data read returns byte from selected ram
// - entry mode latches step direction, auto move
// - glyph address load selects glyph ram
// - text address load selects text ram
// - bias field picks external or internal resistor
// - extended address form stores serial length
// - commands refused while busy
// - counter steps after every data access
// - step direction picks increment or decrement
// - function set carries the set select
module lcdd_core #(
  parameter CLEAR_CYC = `LCDD_CLEAR_CYC,
  parameter EXEC_CYC = `LCDD_EXEC_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // write address channel
  input wire [`LCDD_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [`LCDD_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_FILL = 4'b0010;
  localparam ST_RDWT = 4'b0100;
  localparam ST_WAIT = 4'b1000;
  localparam OP_NONE = 4'h0, OP_CLEAR = 4'h1, OP_HOME = 4'h2, OP_DISP = 4'h3, OP_SHIFT = 4'h4;
  localparam OP_FUNC = 4'h5, OP_STAT = 4'h6, OP_WR = 4'h7, OP_RD = 4'h8, OP_ENTRY = 4'h9;
  localparam OP_GADDR = 4'ha, OP_TADDR = 4'hb, OP_BIAS = 4'hc, OP_SCAN = 4'hd, OP_LEN = 4'he;
  localparam [18:0] CLEAR_N = CLEAR_CYC[18:0];
  localparam [18:0] EXEC_N = EXEC_CYC[18:0];
  // one step of a 7-bit position; glyph addresses wrap within 6 bits
  function [6:0] step7;
    input [6:0] val;
    input up;
    input glyph;
    reg [6:0] nv;
    begin
      nv = up ? val + 7'd1 : val - 7'd1;
      step7 = glyph ? {1'b0, nv[5:0]} : nv;
    end
  endfunction
  reg [3:0] state_r, scan_r, wstrb_r;
  reg [18:0] timer_r;
  reg [6:0] fill_r, ac_r, disp_shift_r, xfer_len_r;
  reg glyph_sel_r, disp_on_r, cur_on_r, blink_r, wide_bus_r, two_line_r, ext_r;
  reg entry_inc_r, auto_move_r, cmd_go_r, aw_got_r, w_got_r;
  reg [1:0] bias_r;
  reg [7:0] res_r;
  reg [9:0] cmd_r;
  reg [`LCDD_AW-1:0] awaddr_r;
  reg [31:0] wdata_r;
  wire busy_flag;
  wire [7:0] mem_rdata;
  wire [7:0] mem_addr;
  reg [3:0] op;
  reg mem_we, mem_re;
  reg [7:0] mem_waddr, mem_wdata;
  // the cycle between bus acceptance and execution already counts as busy
  assign busy_flag = cmd_go_r | (state_r != ST_IDLE);
  assign mem_addr = {glyph_sel_r, ac_r};
  // instruction decode; common group has priority in both sets
  always @* begin
    op = OP_NONE;
    if (cmd_r[`LCDD_CMD_RS] && cmd_r[`LCDD_CMD_RW]) begin
      op = OP_RD;
    end else if (cmd_r[`LCDD_CMD_RS]) begin
      op = OP_WR;
    end else if (cmd_r[`LCDD_CMD_RW]) begin
      op = OP_STAT;
    end else if (cmd_r[7:0] == 8'h01) begin
      op = OP_CLEAR;
    end else if (cmd_r[7:1] == 7'h01) begin
      op = OP_HOME;
    end else if (cmd_r[7:3] == 5'h01) begin
      op = OP_DISP;
    end else if (cmd_r[7:4] == 4'h1) begin
      op = OP_SHIFT;
    end else if (cmd_r[7:5] == 3'h1) begin
      op = OP_FUNC;
    end else if (!ext_r) begin
      if (cmd_r[7:2] == 6'h01) begin
        op = OP_ENTRY;
      end else if (cmd_r[7:6] == 2'h1) begin
        op = OP_GADDR;
      end else if (cmd_r[7]) begin
        op = OP_TADDR;
      end
    end else begin
      if (cmd_r[7:2] == 6'h01) begin
        op = OP_BIAS;
      end else if (cmd_r[7:4] == 4'h0) begin
        op = OP_SCAN;
      end else if (cmd_r[7]) begin
        op = OP_LEN;
      end
    end
  end
  // ram port control
  always @* begin
    mem_we = 1'b0;
    mem_waddr = mem_addr;
    mem_wdata = cmd_r[7:0];
    mem_re = 1'b0;
    if (state_r == ST_FILL) begin
      mem_we = 1'b1;
      mem_waddr = {1'b0, fill_r};
      mem_wdata = `LCDD_SPACE_CODE;
    end else if (state_r == ST_IDLE && cmd_go_r) begin
      mem_we = (op == OP_WR);
      mem_re = (op == OP_RD);
    end
  end
  lcdd_ram u_ram (
    .core_clk(core_clk),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(mem_addr),
    .rd_data(mem_rdata)
  );
  // command execution
  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= 19'd0;
      fill_r <= 7'd0;
      ac_r <= 7'd0;
      glyph_sel_r <= 1'b0;
      disp_on_r <= 1'b0;
      cur_on_r <= 1'b0;
      blink_r <= 1'b0;
      wide_bus_r <= 1'b1;
      two_line_r <= 1'b0;
      ext_r <= 1'b0;
      entry_inc_r <= 1'b1;
      auto_move_r <= 1'b0;
      disp_shift_r <= 7'd0;
      bias_r <= 2'b00;
      scan_r <= 4'h0;
      xfer_len_r <= 7'd0;
      res_r <= 8'h00;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmd_go_r) begin
            timer_r <= EXEC_N;
            state_r <= ST_WAIT;
            case (op)
              OP_CLEAR: begin
                timer_r <= CLEAR_N;
                fill_r <= 7'd0;
                ac_r <= 7'd0;
                glyph_sel_r <= 1'b0;
                disp_shift_r <= 7'd0;
                entry_inc_r <= 1'b1;
                state_r <= ST_FILL;
              end
              OP_HOME: begin
                ac_r <= 7'd0;
                glyph_sel_r <= 1'b0;
                disp_shift_r <= 7'd0;
                state_r <= ST_IDLE;
              end
              OP_DISP: begin
                disp_on_r <= cmd_r[2];
                cur_on_r <= cmd_r[1];
                blink_r <= cmd_r[0];
              end
              OP_SHIFT: begin
                if (cmd_r[3]) begin
                  disp_shift_r <= step7(disp_shift_r, cmd_r[2], 1'b0);
                end else begin
                  ac_r <= step7(ac_r, cmd_r[2], glyph_sel_r);
                end
              end
              OP_FUNC: begin
                wide_bus_r <= cmd_r[4];
                two_line_r <= cmd_r[3];
                ext_r <= cmd_r[2];
              end
              OP_STAT: begin
                // only reached when idle, so the flag always reads clear here
                res_r <= {1'b0, ac_r};
                state_r <= ST_IDLE;
              end
              OP_WR: begin
                ac_r <= step7(ac_r, entry_inc_r, glyph_sel_r);
                if (auto_move_r && !glyph_sel_r) begin
                  disp_shift_r <= step7(disp_shift_r, ~entry_inc_r, 1'b0);
                end
              end
              OP_RD: state_r <= ST_RDWT;
              OP_ENTRY: begin
                entry_inc_r <= cmd_r[1];
                auto_move_r <= cmd_r[0];
              end
              OP_GADDR: begin
                ac_r <= {1'b0, cmd_r[5:0]};
                glyph_sel_r <= 1'b1;
              end
              OP_TADDR: begin
                ac_r <= cmd_r[6:0];
                glyph_sel_r <= 1'b0;
              end
              OP_BIAS: bias_r <= cmd_r[1:0];
              OP_SCAN: scan_r <= cmd_r[3:0];
              OP_LEN: xfer_len_r <= cmd_r[6:0];
              // undecoded words finish in one cycle, like home and status read
              default: state_r <= ST_IDLE;
            endcase
          end
        end
        ST_FILL: begin
          timer_r <= timer_r - 19'd1;
          fill_r <= fill_r + 7'd1;
          if (fill_r == `LCDD_LAST_TEXT) begin
            state_r <= ST_WAIT;
          end
        end
        ST_RDWT: begin
          timer_r <= timer_r - 19'd1;
          res_r <= mem_rdata;
          ac_r <= step7(ac_r, entry_inc_r, glyph_sel_r);
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          timer_r <= timer_r - 19'd1;
          if (timer_r == 19'd1) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // axi4-lite write side; a command write while busy is dropped
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCDD_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= {`LCDD_AW{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      cmd_go_r <= 1'b0;
      cmd_r <= 10'h000;
    end else begin
      cmd_go_r <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_r && w_got_r && !s_axi_bvalid) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `LCDD_RESP_OKAY;
        if (awaddr_r == `LCDD_OFS_CMD) begin
          // both low lanes needed: the command word spans bits 9..0
          if (!busy_flag && wstrb_r[1:0] == 2'b11) begin
            cmd_go_r <= 1'b1;
            cmd_r <= wdata_r[9:0];
          end
        end else begin
          s_axi_bresp <= `LCDD_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // axi4-lite read side
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LCDD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `LCDD_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == `LCDD_OFS_CMD) begin
          s_axi_rdata[9:0] <= cmd_r;
        end else if (s_axi_araddr == `LCDD_OFS_RESULT) begin
          s_axi_rdata[7:0] <= res_r;
        end else if (s_axi_araddr == `LCDD_OFS_STATUS) begin
          s_axi_rdata[`LCDD_ST_BUSY] <= busy_flag;
          s_axi_rdata[`LCDD_ST_EXT] <= ext_r;
          s_axi_rdata[`LCDD_ST_GLYPH] <= glyph_sel_r;
          s_axi_rdata[`LCDD_ST_AC_LSB +: 7] <= ac_r;
          s_axi_rdata[`LCDD_ST_SHIFT_LSB +: 7] <= disp_shift_r;
        end else if (s_axi_araddr == `LCDD_OFS_MODE) begin
          s_axi_rdata[`LCDD_MD_DISP] <= disp_on_r;
          s_axi_rdata[`LCDD_MD_CUR] <= cur_on_r;
          s_axi_rdata[`LCDD_MD_BLINK] <= blink_r;
          s_axi_rdata[`LCDD_MD_WIDE] <= wide_bus_r;
          s_axi_rdata[`LCDD_MD_TWOLINE] <= two_line_r;
          s_axi_rdata[`LCDD_MD_INC] <= entry_inc_r;
          s_axi_rdata[`LCDD_MD_AUTO] <= auto_move_r;
        end else if (s_axi_araddr == `LCDD_OFS_EXTCFG) begin
          s_axi_rdata[`LCDD_EX_BIAS_LSB +: 2] <= bias_r;
          s_axi_rdata[`LCDD_EX_INTRES] <= (bias_r != 2'b00);
          s_axi_rdata[`LCDD_EX_SCAN_LSB +: 4] <= scan_r;
          s_axi_rdata[`LCDD_EX_LEN_LSB +: 7] <= xfer_len_r;
        end else begin
          s_axi_rresp <= `LCDD_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- verification/lcdd_props.sv
// bus handshake assertions for the lcd decoder, bound to its top
`timescale 1ns/1ps
`include "lcdd_defs.vh"
module lcdd_props (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // write side
  input wire [`LCDD_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // read side
  input wire [`LCDD_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_ready: assert property ($rose(rst_n) |-> s_axi_awready && s_axi_wready
    && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid) else $error("bad state after reset");
  chk_b_follows: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_aw_drops: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address not closed");
  chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=>
    s_axi_awready && s_axi_wready) else $error("write side not reopened");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `LCDD_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read carries data");
endmodule
bind lcdd_core lcdd_props chk_u (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

//--- verification/lcdd_host.sv
// host model: axi4-lite master that polls busy before each command
`timescale 1ns/1ps
`include "lcdd_defs.vh"
module lcdd_host (
  // clock
  input wire core_clk,
  // write side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // ready goes up with the request, so each answer is taken at the edge it is seen
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic cmd(input [9:0] c);
    logic [31:0] d;
    logic [1:0] r;
    do rd(`LCDD_OFS_STATUS, d, r); while (d[0] !== 1'b0);
    wr(`LCDD_OFS_CMD, {22'h0, c}, 4'hf, r);
  endtask
endmodule

//--- verification/testbench.sv
// self-checking bench: host model drives the decoder, reference model predicts results
`timescale 1ns/1ps
`include "lcdd_defs.vh"
module testbench;
  localparam int CLR = 300;
  localparam int EXE = 20;
  logic core_clk;
  logic rst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int num_errors = 0;
  int samples_checked = 0;
  logic [15:0] lfsr_r = 16'h831c;
  logic glyph = 0, extended_set_select = 0, inc = 1, autom = 0, wide = 1, two = 0;
  logic [2:0] dcb = 0;
  logic [1:0] bias = 0;
  logic [3:0] scan = 0;
  logic [6:0] ac = 0, shf = 0, len = 0;
  logic [7:0] res = 0;
  logic [7:0] tram [128];
  logic [7:0] gram [64];
  logic [9:0] seq [$] = '{10'h001, 10'h0ff, 10'h300, 10'h00e, 10'h038,
    10'h006, 10'h085, 10'h200, 10'h200, 10'h200, 10'h085, 10'h300, 10'h300,
    10'h300, 10'h004, 10'h200, 10'h100, 10'h007, 10'h200, 10'h002, 10'h014,
    10'h010, 10'h010, 10'h01c, 10'h018, 10'h07f, 10'h200, 10'h07f, 10'h300,
    10'h080, 10'h034, 10'h006, 10'h085, 10'h000, 10'h045, 10'h00a, 10'h020,
    10'h006, 10'h0c0, 10'h005, 10'h200, 10'h040, 10'h010};
  lcdd_core #(.CLEAR_CYC(CLR), .EXEC_CYC(EXE)) dut_u (.core_clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lcdd_host host_u (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  function automatic logic [7:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r[7:0];
  endfunction
  task automatic chk(input string nm, input [31:0] exp, input [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input [7:0] a, input [31:0] exp, input [1:0] er, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk({nm, " resp"}, {30'h0, er}, {30'h0, r});
    chk(nm, exp, d);
  endtask
  task automatic regs();
    rdc(`LCDD_OFS_STATUS, {9'h0, shf, 1'b0, ac, 5'h0, glyph, extended_set_select, 1'b0}, 0, "status");
    rdc(`LCDD_OFS_MODE, {25'h0, autom, inc, two, wide, dcb[0], dcb[1], dcb[2]}, 0,
      "mode");
    rdc(`LCDD_OFS_EXTCFG, {17'h0, len, scan, 1'b0, bias != 0, bias}, 0, "extcfg");
    rdc(`LCDD_OFS_RESULT, {24'h0, res}, 0, "result");
  endtask
  // reference decode, in the same priority as the decoder: common codes before set codes
  task automatic mdl(input [9:0] c, output int n);
    logic [7:0] d;
    d = c[7:0];
    n = EXE;
    if (c[9]) begin
      if (c[8]) res = glyph ? gram[ac[5:0]] : tram[ac];
      else if (glyph) gram[ac[5:0]] = d;
      else tram[ac] = d;
      if (autom && !glyph && !c[8]) shf = shf + (inc ? 7'h7f : 7'h01);
      ac = ac + (inc ? 7'h01 : 7'h7f);
      if (glyph) ac[6] = 1'b0;
    end else if (c[8]) begin
      res = {1'b0, ac};
      n = 0;
    end else if (d == 1) begin
      foreach (tram[i]) tram[i] = 8'h20;
      {glyph, ac, shf} = 0;
      inc = 1;
      n = CLR;
    end else if (d[7:1] == 1) begin
      {glyph, ac, shf} = 0;
      n = 0;
    end else if (d[7:3] == 1) dcb = d[2:0];
    else if (d[7:4] == 1 && d[3]) shf = shf + (d[2] ? 7'h01 : 7'h7f);
    else if (d[7:4] == 1) begin
      ac = ac + (d[2] ? 7'h01 : 7'h7f);
      if (glyph) ac[6] = 1'b0;
    end else if (d[7:5] == 1) {wide, two, extended_set_select} = d[4:2];
    else if (!extended_set_select && d[7:2] == 1) {inc, autom} = d[1:0];
    else if (!extended_set_select && d[7:6] == 1) {glyph, ac} = {2'b10, d[5:0]};
    else if (!extended_set_select && d[7]) {glyph, ac} = {1'b0, d[6:0]};
    else if (extended_set_select && d[7:2] == 1) bias = d[1:0];
    else if (extended_set_select && d == 0) scan = 0;
    else if (extended_set_select && d[7]) len = d[6:0];
    else n = 0;
  endtask
  task automatic ex(input [9:0] c);
    int n;
    int e;
    realtime t0;
    logic [31:0] d;
    logic [1:0] r;
    if (c[9:8] == 2'b10) c[7:0] = rnd();
    mdl(c, n);
    host_u.cmd(c);
    t0 = $realtime;
    if (n == CLR) host_u.wr(`LCDD_OFS_CMD, 32'h241, 4'hf, r);
    if (n == CLR) chk("busy write resp", 0, r);
    do host_u.rd(`LCDD_OFS_STATUS, d, r); while (d[0] !== 1'b0 && $realtime - t0 < 5000);
    e = int'(($realtime - t0) / 5);
    chk("busy time", 1, e + 3 >= n && e <= n + 8);
    regs();
  endtask
  task automatic summarize();
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
  initial begin
    logic [1:0] r;
    rst_n = 0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1;
    regs();
    foreach (seq[i]) ex(seq[i]);
    host_u.wr(`LCDD_OFS_CMD, 32'h002, 4'h1, r);
    chk("narrow write resp", 0, r);
    rdc(`LCDD_OFS_CMD, 32'h010, 0, "command");
    regs();
    rdc(8'h14, 0, `LCDD_RESP_SLVERR, "unmapped read");
    host_u.wr(`LCDD_OFS_RESULT, 32'h0, 4'hf, r);
    chk("read-only write resp", `LCDD_RESP_SLVERR, r);
    summarize();
  end
endmodule
